// ===== hw/cidfs_consts.svh
// Timing constants and pin levels for the caller-id function-select pair.
// Assumes a 10 MHz system clock on both ends.
`ifndef CIDFS_CONSTS_SVH
`define CIDFS_CONSTS_SVH

`define CIDFS_CLK_PERIOD_NS  100
`define CIDFS_BAUD           1200
// One bit time in ns, 1/1200 s rounded down
`define CIDFS_BIT_NS         833333
`define CIDFS_BIT_CYCLES     (`CIDFS_BIT_NS / `CIDFS_CLK_PERIOD_NS)
// Carrier hysteresis, least times
`define CIDFS_CD_ON_US       10000
`define CIDFS_CD_OFF_US      10000
`define CIDFS_CD_ON_CYCLES   ((`CIDFS_CD_ON_US * 1000 + `CIDFS_CLK_PERIOD_NS - 1) / `CIDFS_CLK_PERIOD_NS)
`define CIDFS_CD_OFF_CYCLES  ((`CIDFS_CD_OFF_US * 1000 + `CIDFS_CLK_PERIOD_NS - 1) / `CIDFS_CLK_PERIOD_NS)
// Host shift clock half period in cycles
`define CIDFS_SCLK_HALF      5
`define CIDFS_WORD_BITS      9
`define CIDFS_FIFO_DEPTH     32
`define CIDFS_MODE_BUFFERED  1'b1

`endif

// ===== hw/cidfs_pkg.sv
// Types shared by the device end and the host end.
// Assumes cidfs_consts.svh for all numeric constants.
package cidfs_pkg;

  typedef enum logic [2:0] {
    CIDFS_FSK,
    CIDFS_HYB_TONE,
    CIDFS_LINE_TONE,
    CIDFS_POWER_DOWN,
    CIDFS_FACTORY_TEST
  } cidfs_func_t;

  typedef enum logic [1:0] {
    CIDFS_RX_IDLE,
    CIDFS_RX_START,
    CIDFS_RX_BITS
  } cidfs_rx_state_t;

  typedef enum logic [1:0] {
    CIDFS_RD_IDLE,
    CIDFS_RD_LOW,
    CIDFS_RD_HIGH
  } cidfs_rd_state_t;

endpackage

// ===== hw/cidfs_if.sv
// Pin bundle between the caller-id device and its host controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface cidfs_if;
  logic interface_mode_pin;
  logic function_select_a;
  logic function_select_b;
  logic shift_clock_in;
  logic fsk_data;
  logic shared_ready_steer_n;
  logic carrier_present_n;

  modport dev (
    input  interface_mode_pin,
    input  function_select_a,
    input  function_select_b,
    input  shift_clock_in,
    output fsk_data,
    output shared_ready_steer_n,
    output carrier_present_n
  );

  modport host (
    output interface_mode_pin,
    output function_select_a,
    output function_select_b,
    output shift_clock_in,
    input  fsk_data,
    input  shared_ready_steer_n,
    input  carrier_present_n
  );
endinterface

// ===== hw/cidfs_device.sv
// Caller-id device end: function decode, 1200 baud receiver, word buffer.
// Assumes demodulated level and detector levels synchronous to clk_sys_i.
//
// Contract
// - A=1,B=1 gives FSK, shared pin is ready.
// - A=1,B=0 gives hybrid tone, shared is steering.
// - A=0,B=1 gives line tone, shared is steering.
// - Mode high, selects low means power down.
// - Mode pin picks FSK interface variant.
// - Buffered host with power down ties mode high.
// - Stream host with power down drives all three.
// - FSK/hybrid host ties A high, toggles B.
// - Receive 1200 baud asynchronous serial data.
// - Stream passes bits; buffer holds nine bits.
// - Ready low half bit, first shift ends it.
// - Carrier flag has hysteresis, gates data.
`timescale 1ns/100ps
`include "cidfs_consts.svh"

module cidfs_fifo #(
  parameter int WIDTH = `CIDFS_WORD_BITS,
  parameter int DEPTH = `CIDFS_FIFO_DEPTH
) (
  input  wire logic             clk_sys_i,   // System clock
  input  wire logic             reset_n_i,   // Sync reset, active low
  input  wire logic             in_valid_i,  // Write request
  output logic                  in_ready_o,  // Not full
  input  wire logic [WIDTH-1:0] in_data_i,   // Write data
  output logic                  out_valid_o, // Not empty
  input  wire logic             out_ready_i, // Read request
  output logic      [WIDTH-1:0] out_data_o   // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    push        = in_valid_i && in_ready_o;
    pop         = out_ready_i && out_valid_o;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

module cidfs_device #(
  parameter int BIT_CYCLES = `CIDFS_BIT_CYCLES,
  parameter int CD_ON      = `CIDFS_CD_ON_CYCLES,
  parameter int CD_OFF     = `CIDFS_CD_OFF_CYCLES,
  parameter int FIFO_DEPTH = `CIDFS_FIFO_DEPTH
) (
  input  wire logic  clk_sys_i,        // System clock
  input  wire logic  reset_n_i,        // Sync reset, active low
  cidfs_if.dev       link,             // Pins toward host
  input  wire logic  line_fsk_level_i, // Demodulated line level, mark=1
  input  wire logic  carrier_raw_i,    // Raw carrier energy present
  input  wire logic  line_tone_i,      // Qualified tone on line amp
  input  wire logic  hybrid_tone_i,    // Qualified tone on hybrid amp
  output logic       power_down_o,     // Device powered down
  output logic       hybrid_sel_o,     // Hybrid amp selected
  output logic       overrun_o         // Word lost, buffer full
);
  import cidfs_pkg::*;

  localparam int HALF = BIT_CYCLES / 2;

  cidfs_func_t     func;
  logic            buffered;
  logic            carrier_on;
  logic [19:0]     cd_cnt;
  cidfs_rx_state_t rx_state;
  logic [15:0]     rx_timer;
  logic [3:0]      rx_nbit;
  logic [8:0]      rx_shift;
  logic            word_done;
  logic [8:0]      out_buf;
  logic [3:0]      out_left;
  logic [15:0]     dr_timer;
  logic            dr_low;
  logic            sclk_prev;
  logic            data_q;
  logic            shared_q;
  logic            cd_n_q;
  logic            pd_q;
  logic            hyb_q;
  logic            ovr_q;
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  logic            fifo_pop;
  logic [8:0]      fifo_out_data;

  cidfs_func_t     next_func;
  logic            next_carrier_on;
  logic [19:0]     next_cd_cnt;
  cidfs_rx_state_t next_rx_state;
  logic [15:0]     next_rx_timer;
  logic [3:0]      next_rx_nbit;
  logic [8:0]      next_rx_shift;
  logic            next_word_done;
  logic [8:0]      next_out_buf;
  logic [3:0]      next_out_left;
  logic [15:0]     next_dr_timer;
  logic            next_dr_low;
  logic            next_data_q;
  logic            next_shared_q;
  logic            next_cd_n_q;
  logic            next_ovr_q;
  logic            sclk_rise;

  assign link.fsk_data             = data_q;
  assign link.shared_ready_steer_n = shared_q;
  assign link.carrier_present_n    = cd_n_q;
  assign power_down_o              = pd_q;
  assign hybrid_sel_o              = hyb_q;
  assign overrun_o                 = ovr_q;

  // --------------------------------------------------------------
  // Function decode and carrier hysteresis
  // --------------------------------------------------------------
  always_comb begin
    unique case ({link.function_select_a, link.function_select_b})
      2'h3: next_func = CIDFS_FSK;
      2'h2: next_func = CIDFS_HYB_TONE;
      2'h1: next_func = CIDFS_LINE_TONE;
      2'h0: next_func = link.interface_mode_pin ? CIDFS_POWER_DOWN : CIDFS_FACTORY_TEST;
    endcase
    next_carrier_on = carrier_on;
    next_cd_cnt     = '0;
    if (func != CIDFS_FSK) begin
      next_carrier_on = 1'b0;
    end else if (carrier_raw_i != carrier_on) begin
      // Level must persist before the flag follows it
      next_cd_cnt = cd_cnt + 20'h0_0001;
      if (cd_cnt == (carrier_on ? 20'(CD_OFF-1) : 20'(CD_ON-1))) begin
        next_carrier_on = carrier_raw_i;
        next_cd_cnt     = '0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      func       <= CIDFS_POWER_DOWN;
      buffered   <= 1'b1;
      carrier_on <= 1'b0;
      cd_cnt     <= '0;
    end else begin
      func       <= next_func;
      buffered   <= link.interface_mode_pin;
      carrier_on <= next_carrier_on;
      cd_cnt     <= next_cd_cnt;
    end
  end

  // --------------------------------------------------------------
  // Serial receiver, 1200 baud, start, 8 data LSB first, stop
  // --------------------------------------------------------------
  always_comb begin
    next_rx_state  = rx_state;
    next_rx_timer  = rx_timer + 16'h0001;
    next_rx_nbit   = rx_nbit;
    next_rx_shift  = rx_shift;
    next_word_done = 1'b0;
    if (!carrier_on) begin
      next_rx_state = CIDFS_RX_IDLE;
      next_rx_timer = '0;
    end else begin
      unique case (rx_state)
        CIDFS_RX_IDLE: begin
          next_rx_timer = '0;
          if (!line_fsk_level_i) begin
            next_rx_state = CIDFS_RX_START;
          end
        end
        CIDFS_RX_START: begin
          if (rx_timer == 16'(HALF-1)) begin
            next_rx_timer = '0;
            next_rx_nbit  = '0;
            next_rx_state = line_fsk_level_i ? CIDFS_RX_IDLE : CIDFS_RX_BITS;
          end
        end
        CIDFS_RX_BITS: begin
          if (rx_timer == 16'(BIT_CYCLES-1)) begin
            next_rx_timer = '0;
            next_rx_shift = {line_fsk_level_i, rx_shift[8:1]};
            next_rx_nbit  = rx_nbit + 4'h1;
            if (rx_nbit == 4'h8) begin
              next_word_done = 1'b1;
              next_rx_state  = CIDFS_RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rx_state  <= CIDFS_RX_IDLE;
      rx_timer  <= '0;
      rx_nbit   <= '0;
      rx_shift  <= '0;
      word_done <= 1'b0;
    end else begin
      rx_state  <= next_rx_state;
      rx_timer  <= next_rx_timer;
      rx_nbit   <= next_rx_nbit;
      rx_shift  <= next_rx_shift;
      word_done <= next_word_done;
    end
  end

  // --------------------------------------------------------------
  // Word queue toward the nine-bit host buffer
  // --------------------------------------------------------------
  cidfs_fifo #(
    .WIDTH (`CIDFS_WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (word_done && buffered),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_shift),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // --------------------------------------------------------------
  // Pin outputs per function and interface variant
  // --------------------------------------------------------------
  always_comb begin
    sclk_rise     = link.shift_clock_in && !sclk_prev;
    fifo_pop      = 1'b0;
    next_out_buf  = out_buf;
    next_out_left = out_left;
    next_dr_timer = dr_timer + 16'h0001;
    next_dr_low   = dr_low;
    next_ovr_q    = ovr_q || (word_done && buffered && !fifo_in_ready);
    next_data_q   = 1'b1;
    next_shared_q = 1'b1;
    next_cd_n_q   = !carrier_on;
    if (dr_low && dr_timer == 16'(HALF-1)) begin
      next_dr_low = 1'b0;
    end
    unique case (func)
      CIDFS_FSK: begin
        if (buffered) begin
          // Hold start bit off, stop bit rides above the data byte
          if (sclk_rise && out_left != 4'h0) begin
            next_out_buf  = {1'b1, out_buf[8:1]};
            next_out_left = out_left - 4'h1;
            next_dr_low   = 1'b0;
          end else if (out_left == 4'h0 && fifo_out_valid) begin
            fifo_pop      = 1'b1;
            next_out_buf  = fifo_out_data;
            next_out_left = 4'(`CIDFS_WORD_BITS);
            next_dr_low   = 1'b1;
            next_dr_timer = '0;
          end
          next_data_q = next_out_buf[0];
        end else begin
          next_data_q = carrier_on ? line_fsk_level_i : 1'b1;
          if (word_done) begin
            next_dr_low   = 1'b1;
            next_dr_timer = '0;
          end
        end
        next_shared_q = !next_dr_low;
      end
      CIDFS_HYB_TONE:  next_shared_q = !hybrid_tone_i;
      CIDFS_LINE_TONE: next_shared_q = !line_tone_i;
      default: begin
        next_cd_n_q = 1'b1;
        // Power down or test code clears the flag, a word lost this cycle still sets it
        next_ovr_q  = word_done && buffered && !fifo_in_ready;
      end
    endcase
    if (func != CIDFS_FSK) begin
      next_out_left = '0;
      next_dr_low   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      out_buf   <= 9'h1ff;
      out_left  <= '0;
      dr_timer  <= '0;
      dr_low    <= 1'b0;
      sclk_prev <= 1'b0;
      data_q    <= 1'b1;
      shared_q  <= 1'b1;
      cd_n_q    <= 1'b1;
      pd_q      <= 1'b1;
      hyb_q     <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      out_buf   <= next_out_buf;
      out_left  <= next_out_left;
      dr_timer  <= next_dr_timer;
      dr_low    <= next_dr_low;
      sclk_prev <= link.shift_clock_in;
      data_q    <= next_data_q;
      shared_q  <= next_shared_q;
      cd_n_q    <= next_cd_n_q;
      pd_q      <= (func == CIDFS_POWER_DOWN);
      hyb_q     <= (func == CIDFS_HYB_TONE);
      ovr_q     <= next_ovr_q;
    end
  end
endmodule

// ===== hw/cidfs_host.sv
// Host controller end: drives the three select pins, reads buffered words.
// Assumes the device end on the same clock through cidfs_if.
`timescale 1ns/100ps
`include "cidfs_consts.svh"

module cidfs_host #(
  parameter int SCLK_HALF = `CIDFS_SCLK_HALF
) (
  input  wire logic                  clk_sys_i,       // System clock
  input  wire logic                  reset_n_i,       // Sync reset, active low
  cidfs_if.host                      link,            // Pins toward device
  input  wire cidfs_pkg::cidfs_func_t req_func_i,     // Requested function
  input  wire logic                  req_buffered_i,  // 1 = buffered interface
  output logic [7:0]                 word_o,          // Last word read
  output logic                       word_valid_o,    // One-cycle word strobe
  output logic                       framing_err_o,   // Stop bit was zero
  output logic                       stream_bit_o,    // Stream data copy
  output logic                       carrier_o,       // Carrier seen
  output logic                       event_o          // Shared pin low
);
  import cidfs_pkg::*;

  logic            mode_q;
  logic            sel_a_q;
  logic            sel_b_q;
  logic            sclk_q;
  logic            shared_prev;
  cidfs_rd_state_t rd_state;
  logic [15:0]     rd_timer;
  logic [3:0]      rd_nbit;
  logic [8:0]      rd_shift;
  logic [7:0]      word_q;
  logic            valid_q;
  logic            ferr_q;
  logic            next_mode;
  logic            next_sel_a;
  logic            next_sel_b;
  logic            next_sclk;
  cidfs_rd_state_t next_rd_state;
  logic [15:0]     next_rd_timer;
  logic [3:0]      next_rd_nbit;
  logic [8:0]      next_rd_shift;
  logic [7:0]      next_word;
  logic            next_valid;
  logic            next_ferr;

  assign link.interface_mode_pin = mode_q;
  assign link.function_select_a  = sel_a_q;
  assign link.function_select_b  = sel_b_q;
  assign link.shift_clock_in     = sclk_q;
  assign word_o                  = word_q;
  assign word_valid_o            = valid_q;
  assign framing_err_o           = ferr_q;

  // --------------------------------------------------------------
  // Select pin drive
  // --------------------------------------------------------------
  always_comb begin
    next_mode  = req_buffered_i;
    next_sel_a = 1'b0;
    next_sel_b = 1'b0;
    unique case (req_func_i)
      CIDFS_FSK: begin
        next_sel_a = 1'b1;
        next_sel_b = 1'b1;
      end
      CIDFS_HYB_TONE:  next_sel_a = 1'b1;
      CIDFS_LINE_TONE: next_sel_b = 1'b1;
      // Reserved test code is never sent; power down stands in
      default:         next_mode  = 1'b1;
    endcase
  end

  // --------------------------------------------------------------
  // Nine-pulse buffer read on each ready strobe
  // --------------------------------------------------------------
  always_comb begin
    next_rd_state = rd_state;
    next_rd_timer = rd_timer + 16'h0001;
    next_rd_nbit  = rd_nbit;
    next_rd_shift = rd_shift;
    next_sclk     = sclk_q;
    next_word     = word_q;
    next_valid    = 1'b0;
    next_ferr     = ferr_q;
    unique case (rd_state)
      CIDFS_RD_IDLE: begin
        next_rd_timer = '0;
        next_rd_nbit  = '0;
        next_sclk     = 1'b0;
        if (sel_a_q && sel_b_q && mode_q == `CIDFS_MODE_BUFFERED &&
            shared_prev && !link.shared_ready_steer_n) begin
          next_rd_state = CIDFS_RD_LOW;
        end
      end
      CIDFS_RD_LOW: begin
        if (rd_timer == 16'(SCLK_HALF-1)) begin
          next_rd_timer = '0;
          next_sclk     = 1'b1;
          next_rd_shift = {link.fsk_data, rd_shift[8:1]};
          next_rd_state = CIDFS_RD_HIGH;
        end
      end
      CIDFS_RD_HIGH: begin
        if (rd_timer == 16'(SCLK_HALF-1)) begin
          next_rd_timer = '0;
          next_sclk     = 1'b0;
          next_rd_nbit  = rd_nbit + 4'h1;
          next_rd_state = CIDFS_RD_LOW;
          if (rd_nbit == 4'(`CIDFS_WORD_BITS-1)) begin
            next_word     = rd_shift[7:0];
            next_ferr     = !rd_shift[8];
            next_valid    = 1'b1;
            next_rd_state = CIDFS_RD_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mode_q       <= 1'b1;
      sel_a_q      <= 1'b0;
      sel_b_q      <= 1'b0;
      sclk_q       <= 1'b0;
      shared_prev  <= 1'b1;
      rd_state     <= CIDFS_RD_IDLE;
      rd_timer     <= '0;
      rd_nbit      <= '0;
      rd_shift     <= '0;
      word_q       <= '0;
      valid_q      <= 1'b0;
      ferr_q       <= 1'b0;
      stream_bit_o <= 1'b1;
      carrier_o    <= 1'b0;
      event_o      <= 1'b0;
    end else begin
      mode_q       <= next_mode;
      sel_a_q      <= next_sel_a;
      sel_b_q      <= next_sel_b;
      sclk_q       <= next_sclk;
      shared_prev  <= link.shared_ready_steer_n;
      rd_state     <= next_rd_state;
      rd_timer     <= next_rd_timer;
      rd_nbit      <= next_rd_nbit;
      rd_shift     <= next_rd_shift;
      word_q       <= next_word;
      valid_q      <= next_valid;
      ferr_q       <= next_ferr;
      stream_bit_o <= link.fsk_data;
      carrier_o    <= !link.carrier_present_n;
      event_o      <= !link.shared_ready_steer_n;
    end
  end
endmodule

// ===== verif/cidfs_props.sv
// Pin assertions for the link between host and device ends.
// Assumes one instance beside cidfs_if in tb_top.
`timescale 1ns/100ps
module cidfs_props #(
  parameter int HALF = 20
) (
  input wire logic clk_sys_i,            // System clock
  input wire logic reset_n_i,            // Sync reset, active low
  input wire logic interface_mode_pin,   // Mode pin
  input wire logic function_select_a,    // Select a
  input wire logic function_select_b,    // Select b
  input wire logic shift_clock_in,       // Host shift clock
  input wire logic fsk_data,             // Data pin
  input wire logic shared_ready_steer_n, // Ready or steer
  input wire logic carrier_present_n     // Carrier flag
);
  logic [2:0] pins;
  logic [2:0] pins_q;
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic [5:0] low_run;
  logic [5:0] next_low_run;
  logic       fsk;
  assign pins = {interface_mode_pin, function_select_a, function_select_b};
  assign fsk = function_select_a && function_select_b && settle > 3'd3;
  // ----------------------------------------
  // Cycles since pins moved, ready low run
  // ----------------------------------------
  always_comb begin
    next_settle = (pins != pins_q) ? 3'd0 : settle + {2'd0, settle != 3'd7};
    next_low_run = (fsk && !shared_ready_steer_n) ? low_run + 6'd1 : 6'd0;
    if (!reset_n_i) begin
      next_settle = 3'd0;
      next_low_run = 6'd0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    pins_q <= pins;
    settle <= next_settle;
    low_run <= next_low_run;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  chk_no_factory_code: assert property (pins != 3'b000)
    else $error("select pins all low");
  chk_pd_outputs_idle: assert property (
    settle > 3'd2 && pins == 3'b100 |-> shared_ready_steer_n && carrier_present_n && fsk_data)
    else $error("output active in power down");
  chk_carrier_fsk_only: assert property (
    settle > 3'd2 && !(function_select_a && function_select_b) |-> carrier_present_n)
    else $error("carrier flag outside fsk");
  chk_data_gated: assert property (
    (fsk && !interface_mode_pin && carrier_present_n) [*3] |-> fsk_data)
    else $error("stream data without carrier");
  chk_ready_width: assert property (
    fsk && !interface_mode_pin && $fell(shared_ready_steer_n)
    |-> (!shared_ready_steer_n) [*8] ##12 !shared_ready_steer_n ##1 shared_ready_steer_n)
    else $error("stream ready width wrong");
  chk_ready_max_low: assert property (low_run <= HALF)
    else $error("ready low too long");
  chk_ready_shift_clear: assert property (
    fsk && interface_mode_pin && !shared_ready_steer_n && $rose(shift_clock_in)
    |-> ##[1:3] shared_ready_steer_n)
    else $error("shift did not clear ready");
  chk_shift_buffered: assert property ($rose(shift_clock_in) |-> pins == 3'b111)
    else $error("shift outside buffered fsk");
endmodule

// ===== verif/tb_top.sv
// Bench joining host and device ends through cidfs_if.
// Assumes shortened bit, carrier and shift timing parameters.
`timescale 1ns/100ps
module tb_top;
  import cidfs_pkg::*;
  localparam int BIT = 40;
  localparam int HALF = BIT / 2;
  logic        clk_sys_i;
  logic        reset_n_i;
  logic        line, carrier, tone_l, tone_h, req_buf;
  logic        pd, hyb, ovr, wv, fe, sbit, car, evt, prev_evt;
  logic [7:0]  word;
  logic [8:0]  words[$];
  cidfs_func_t req;
  int          n_fail = 0, n_compared = 0, n_ready = 0, cycles = 0;
  cidfs_if lnk();
  cidfs_device #(.BIT_CYCLES(BIT), .CD_ON(10), .CD_OFF(10), .FIFO_DEPTH(32)) u_cidfs_device (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(lnk), .line_fsk_level_i(line),
    .carrier_raw_i(carrier), .line_tone_i(tone_l), .hybrid_tone_i(tone_h),
    .power_down_o(pd), .hybrid_sel_o(hyb), .overrun_o(ovr));
  cidfs_host #(.SCLK_HALF(2)) u_cidfs_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .link(lnk), .req_func_i(req), .req_buffered_i(req_buf), .word_o(word),
    .word_valid_o(wv), .framing_err_o(fe), .stream_bit_o(sbit), .carrier_o(car),
    .event_o(evt));
  cidfs_props #(.HALF(HALF)) u_cidfs_props (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .interface_mode_pin(lnk.interface_mode_pin), .function_select_a(lnk.function_select_a),
    .function_select_b(lnk.function_select_b), .shift_clock_in(lnk.shift_clock_in),
    .fsk_data(lnk.fsk_data), .shared_ready_steer_n(lnk.shared_ready_steer_n),
    .carrier_present_n(lnk.carrier_present_n));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------
  // Monitors and watchdog
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    prev_evt <= evt;
    if (evt === 1'b1 && prev_evt === 1'b0) n_ready <= n_ready + 1;
    if (wv === 1'b1) words.push_back({fe, word});
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic cmpv(input logic [8:0] got, input logic [8:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic setf(input cidfs_func_t f, input logic b, input logic [2:0] pins);
    req <= f;
    req_buf <= b;
    repeat (8) @(posedge clk_sys_i);
    cmpv({6'd0, lnk.interface_mode_pin, lnk.function_select_a, lnk.function_select_b},
      {6'd0, pins}, "pins");
  endtask
  task automatic send(input logic [7:0] d, input logic stop, input logic chk);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (HALF) @(posedge clk_sys_i);
      if (chk) cmp1(lnk.fsk_data, f[i] | !carrier, "stream bit");
      if (chk) cmp1(sbit, f[i] | !carrier, "host stream bit");
      repeat (HALF) @(posedge clk_sys_i);
    end
    line <= 1'b1;
    @(posedge clk_sys_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_down();
    setf(CIDFS_FACTORY_TEST, 1'b0, 3'b100);
    setf(CIDFS_POWER_DOWN, 1'b1, 3'b100);
    cmp1(pd, 1'b1, "power down");
    cmp1(hyb, 1'b0, "hybrid off");
    cmp1(ovr, 1'b0, "overrun");
  endtask
  task automatic t_tones();
    for (int k = 0; k < 4; k++) begin
      setf(k[0] ? CIDFS_LINE_TONE : CIDFS_HYB_TONE, k[1], {k[1], !k[0], k[0]});
      tone_l <= !k[0];
      tone_h <= k[0];
      repeat (5) @(posedge clk_sys_i);
      cmp1(lnk.shared_ready_steer_n, 1'b1, "other tone");
      tone_l <= k[0];
      tone_h <= !k[0];
      repeat (5) @(posedge clk_sys_i);
      cmp1(lnk.shared_ready_steer_n, 1'b0, "steer");
      cmp1(evt, 1'b1, "host event");
      cmp1(hyb, !k[0], "amp select");
      cmp1(pd, 1'b0, "awake");
      tone_l <= 1'b0;
      tone_h <= 1'b0;
    end
  endtask
  task automatic t_stream();
    int r;
    setf(CIDFS_FSK, 1'b0, 3'b011);
    carrier <= 1'b1;
    repeat (15) @(posedge clk_sys_i);
    cmp1(lnk.carrier_present_n, 1'b0, "carrier");
    cmp1(car, 1'b1, "host carrier");
    r = n_ready;
    send(8'hA5, 1'b1, 1'b1);
    repeat (5) @(posedge clk_sys_i);
    cmp1(n_ready == r + 1, 1'b1, "ready pulses");
  endtask
  task automatic t_buffered();
    setf(CIDFS_FSK, 1'b1, 3'b111);
    repeat (15) @(posedge clk_sys_i);
    words.delete();
    send(8'hA5, 1'b1, 1'b0);
    send(8'h3C, 1'b0, 1'b0);
    for (int i = 0; i < 300 && words.size() < 2; i++) @(posedge clk_sys_i);
    cmp1(words.size() == 2, 1'b1, "word count");
    cmpv(words[0], {1'b0, 8'hA5}, "word one");
    cmpv(words[1], {1'b1, 8'h3C}, "word two framing");
    cmp1(ovr, 1'b0, "no overrun");
  endtask
  task automatic t_no_carrier();
    int r;
    carrier <= 1'b0;
    repeat (15) @(posedge clk_sys_i);
    cmp1(lnk.carrier_present_n, 1'b1, "carrier off");
    words.delete();
    send(8'h5A, 1'b1, 1'b0);
    repeat (60) @(posedge clk_sys_i);
    cmp1(words.size() == 0, 1'b1, "data ignored");
    setf(CIDFS_FSK, 1'b0, 3'b011);
    r = n_ready;
    send(8'h00, 1'b1, 1'b1);
    cmp1(n_ready == r, 1'b1, "no ready without carrier");
  endtask
  initial begin
    reset_n_i = 1'b0;
    line = 1'b1;
    carrier = 1'b0;
    tone_l = 1'b0;
    tone_h = 1'b0;
    req = CIDFS_POWER_DOWN;
    req_buf = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_power_down();
    t_tones();
    t_stream();
    t_buffered();
    t_no_carrier();
    t_power_down();
    results();
  end
endmodule
